// ==== verilog/index_load_pkg.sv ====
// Package with constants for the index switch load and column variable block.
// How it works
// RULE1: First-index load adds accumulator digit to first.
// RULE2: Second-index load adds accumulator digit to second.
// RULE3: Combined load adds digit to both indexes.
// RULE4: Program homes index to zero before loading.
// RULE5: Smaller machine: no band switch loading.
// RULE6: Column variable is ten values from pins.
// RULE7: Column variable feeds third-area operand.
// RULE8: Column variable invalid between tab stops.
// RULE9: With option, interlock holds start until column.
// RULE10: Without option, execution continues during travel.
// RULE11: Expanded machine band-load adds digit to band.
// RULE12: Index digits wrap modulo ten.
package index_load_pkg;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [3:0] DIGIT_RADIX = 4'ha;
	localparam logic [1:0] BAND_ZERO = 2'h0;
	localparam logic [2:0] BAND_RADIX = 3'h4;
	// Second-area codes of the load instructions.
	localparam logic [3:0] OP_LOAD_FIRST = 4'h4;
	localparam logic [3:0] OP_LOAD_SECOND = 4'h5;
	localparam logic [3:0] OP_LOAD_BOTH = 4'h6;
	localparam logic [3:0] OP_LOAD_BAND = 4'h7;
	typedef enum logic [1:0] {
		RUN_FREE = 2'b01,
		WAIT_COLUMN = 2'b10
	} interlock_e;
endpackage

// ==== verilog/digit_adder.sv ====
// Modulo-ten digit adder used for every index switch.
`timescale 1ns/1ns
`default_nettype none
module digit_adder
	import index_load_pkg::*;
(
	input wire logic [3:0] current, // Present switch digit.
	input wire logic [3:0] addend, // Accumulator low digit.
	output logic [3:0] sum // Wrapped result.
);
	logic [4:0] raw;
	// Sum wraps back into 0..9 when it passes nine.
	always_comb begin
		raw = {1'b0, current} + {1'b0, addend};
		if (raw > {1'b0, DIGIT_MAX}) begin
			sum = 4'(raw - {1'b0, DIGIT_RADIX}); // RULE12
		end else begin
			sum = raw[3:0];
		end
	end
endmodule
`default_nettype wire

// ==== verilog/index_switch_load_and_column_var.sv ====
// Index switch accumulator load and carriage column variable control.
`timescale 1ns/1ns
`default_nettype none
module index_switch_load_and_column_var
	import index_load_pkg::*;
#(
	parameter bit EXPANDED_MEMORY = 1'b0,
	parameter bit COLUMN_OPTION = 1'b1
)(
	input wire logic clk_sys, // 125 MHz system clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic execStrobe, // One-cycle instruction execute pulse.
	input wire logic [3:0] opCode, // Second-area code of an H instruction.
	input wire logic [3:0] accDigit, // Accumulator least significant digit.
	input wire logic homeFirst, // Home first index to homeValue.
	input wire logic homeSecond, // Home second index to homeValue.
	input wire logic homeBand, // Home band switch to homeValue.
	input wire logic [3:0] homeValue, // Home target digit.
	input wire logic [3:0] columnPins, // Carriage pin digit at a tab stop.
	input wire logic atTabStop, // Carriage rests at a tab stop.
	input wire logic printOrKeyDone, // Pulse at end of print or keyboard step.
	input wire logic selectColumn, // Third area pinned to column variable.
	input wire logic [3:0] thirdAreaIn, // Third-area value from other sources.
	output logic [3:0] firstIndex, // First index switch.
	output logic [3:0] secondIndex, // Second index switch.
	output logic [1:0] bandSwitch, // Band selector.
	output logic [3:0] columnValue, // Column variable value.
	output logic columnValid, // Column variable has a value.
	output logic [3:0] thirdAreaOut, // Operand for the third area.
	output logic thirdAreaValid, // Operand is usable.
	output logic startHold // Program start held off.
);
	// Adder results, load decodes, interlock state and the column operand.
	logic [3:0] next_first;
	logic [3:0] next_second;
	logic [2:0] bandRaw;
	logic [1:0] next_band;
	logic loadFirst;
	logic loadSecond;
	logic loadBand;
	interlock_e state;
	logic [3:0] colDigit;
	logic [3:0] homeDigit;
	logic [3:0] colOperand;
	logic colPresent;

	// One wrapping adder per index switch, both fed the accumulator digit.
	digit_adder firstAdd (
		.current(firstIndex),
		.addend(accDigit),
		.sum(next_first)
	);

	digit_adder secondAdd (
		.current(secondIndex),
		.addend(accDigit),
		.sum(next_second)
	);

	// Decode of the load instructions; nothing loads without the execute pulse.
	always_comb begin
		loadFirst = 1'b0;
		loadSecond = 1'b0;
		loadBand = 1'b0;
		if (execStrobe) begin
			case (opCode)
				OP_LOAD_FIRST: begin
					loadFirst = 1'b1; // RULE1
				end
				OP_LOAD_SECOND: begin
					loadSecond = 1'b1; // RULE2
				end
				OP_LOAD_BOTH: begin
					loadFirst = 1'b1; // RULE3
					loadSecond = 1'b1; // RULE3
				end
				OP_LOAD_BAND: begin
					loadBand = EXPANDED_MEMORY; // RULE5 RULE11
				end
				default: begin
					loadBand = 1'b0;
				end
			endcase
		end
	end

	// Home targets above nine are no switch position, so the two index switches home to zero.
	always_comb begin
		if (homeValue > DIGIT_MAX) begin
			homeDigit = DIGIT_ZERO;
		end else begin
			homeDigit = homeValue;
		end
	end

	// Band sum wraps modulo the four bands.
	always_comb begin
		bandRaw = {1'b0, bandSwitch} + 3'(accDigit[1:0]);
		if (bandRaw >= BAND_RADIX) begin
			next_band = 2'(bandRaw - BAND_RADIX);
		end else begin
			next_band = bandRaw[1:0];
		end
	end

	// First index: home or accumulator add.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			firstIndex <= DIGIT_ZERO;
		end else if (homeFirst) begin
			firstIndex <= homeDigit;
		end else if (loadFirst) begin
			firstIndex <= next_first; // RULE1 RULE12
		end
	end

	// Second index: home or accumulator add.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			secondIndex <= DIGIT_ZERO;
		end else if (homeSecond) begin
			secondIndex <= homeDigit;
		end else if (loadSecond) begin
			secondIndex <= next_second; // RULE2 RULE12
		end
	end

	// Band switch, only present on the expanded machine.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bandSwitch <= BAND_ZERO;
		end else if (EXPANDED_MEMORY && homeBand) begin
			bandSwitch <= homeValue[1:0];
		end else if (loadBand) begin
			bandSwitch <= next_band; // RULE11
		end
	end

	// Pins out of range are clamped into the ten legal values.
	always_comb begin
		if (columnPins > DIGIT_MAX) begin
			colDigit = DIGIT_MAX; // RULE6
		end else begin
			colDigit = columnPins; // RULE6
		end
	end

	// The variable exists only at a stop; between stops it reads zero and invalid.
	always_comb begin
		colOperand = DIGIT_ZERO;
		colPresent = 1'b0;
		if (atTabStop) begin
			colOperand = colDigit; // RULE6
			colPresent = COLUMN_OPTION; // RULE8
		end
	end

	// Column variable follows the pins only at a tab stop.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			columnValue <= DIGIT_ZERO;
			columnValid <= 1'b0;
		end else begin
			columnValue <= colOperand; // RULE6
			columnValid <= colPresent; // RULE8
		end
	end

	// Third-area operand mux, registered.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			thirdAreaOut <= DIGIT_ZERO;
			thirdAreaValid <= 1'b0;
		end else if (selectColumn) begin
			thirdAreaOut <= colOperand; // RULE7
			thirdAreaValid <= colPresent; // RULE7 RULE8
		end else begin
			thirdAreaOut <= thirdAreaIn;
			thirdAreaValid <= 1'b1;
		end
	end

	// Interlock: after a print or keyboard step, wait for the carriage to land.
	// The column variable has no value while the carriage travels, so a start
	// taken then would run with no operand. Leaving the wait needs a stop seen
	// in a cycle with no fresh done pulse, so back-to-back steps keep waiting.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= RUN_FREE;
		end else begin
			case (state)
				RUN_FREE: begin
					if (COLUMN_OPTION && printOrKeyDone) begin
						state <= WAIT_COLUMN; // RULE9
					end
				end
				WAIT_COLUMN: begin
					if (atTabStop && !printOrKeyDone) begin
						state <= RUN_FREE; // RULE9
					end
				end
				default: begin
					state <= RUN_FREE;
				end
			endcase
		end
	end

	// Hold flag; without the option it never rises and the program runs on.
	// The done pulse sets the hold at once, ahead of any clear, so a start
	// request in the cycle after the pulse is already refused. The hold then
	// stays up while the interlock waits and the carriage is off its stops.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			startHold <= 1'b0;
		end else if (!COLUMN_OPTION) begin
			startHold <= 1'b0; // RULE10
		end else if (printOrKeyDone) begin
			startHold <= 1'b1; // RULE9
		end else begin
			startHold <= (state == WAIT_COLUMN) && !atTabStop;
		end
	end
endmodule
`default_nettype wire

// ==== verification/index_load_properties.sv ====
// Checker for the index load and column block.
`timescale 1ns/1ns
`default_nettype none
module index_load_properties #(
	parameter bit EXPANDED_MEMORY = 1'b0,
	parameter bit COLUMN_OPTION = 1'b1
)(
	input wire logic clk_sys, // System clock.
	input wire logic reset_n, // Reset, active low.
	input wire logic execStrobe, // Execute pulse.
	input wire logic [3:0] opCode, // Load instruction code.
	input wire logic [3:0] accDigit, // Accumulator low digit.
	input wire logic homeFirst, // Home first index.
	input wire logic homeSecond, // Home second index.
	input wire logic homeBand, // Home band switch.
	input wire logic [3:0] columnPins, // Carriage pin digit.
	input wire logic atTabStop, // Carriage at a stop.
	input wire logic printOrKeyDone, // Print or keyboard step done.
	input wire logic selectColumn, // Column variable selected.
	input wire logic [3:0] firstIndex, // First index switch.
	input wire logic [3:0] secondIndex, // Second index switch.
	input wire logic [1:0] bandSwitch, // Band selector.
	input wire logic [3:0] columnValue, // Column variable value.
	input wire logic columnValid, // Column variable valid.
	input wire logic [3:0] thirdAreaOut, // Third-area operand.
	input wire logic thirdAreaValid, // Operand usable.
	input wire logic startHold // Program start held.
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Sum of two digits, wrapped at ten.
	function automatic logic [3:0] add10(input logic [3:0] a, input logic [3:0] b);
		return 4'((5'(a) + 5'(b)) % 5'd10);
	endfunction
	a_first_load: assert property (execStrobe && !homeFirst && opCode inside {4'h4, 4'h6} |=>
		firstIndex == add10($past(firstIndex), $past(accDigit))) else $error("first sum");
	a_second_load: assert property (execStrobe && !homeSecond && opCode inside {4'h5, 4'h6} |=>
		secondIndex == add10($past(secondIndex), $past(accDigit))) else $error("second sum");
	a_band_fixed: assert property (EXPANDED_MEMORY || bandSwitch == 2'h0) else $error("band");
	a_col_gone: assert property (!atTabStop |=> !columnValid) else $error("column valid");
	a_col_value: assert property (COLUMN_OPTION && atTabStop |=>
		columnValid && columnValue == (($past(columnPins) > 4'h9) ? 4'h9 : $past(columnPins)))
		else $error("column value");
	a_third_col: assert property (COLUMN_OPTION && selectColumn && atTabStop |=>
		thirdAreaValid && thirdAreaOut == (($past(columnPins) > 4'h9) ? 4'h9 : $past(columnPins)))
		else $error("third area");
	a_hold_set: assert property (COLUMN_OPTION && printOrKeyDone |=> startHold) else $error("hold");
	a_hold_free: assert property (startHold && atTabStop && !printOrKeyDone |=> !startHold)
		else $error("hold stuck");
	a_hold_off: assert property (COLUMN_OPTION || !startHold)
		else $error("hold without option");
	a_band_load: assert property (EXPANDED_MEMORY && execStrobe && !homeBand &&
		opCode == 4'h7 |=> bandSwitch == 2'($past(bandSwitch) + $past(accDigit[1:0])))
		else $error("band sum");
endmodule
bind index_switch_load_and_column_var index_load_properties #(
	.EXPANDED_MEMORY(EXPANDED_MEMORY), .COLUMN_OPTION(COLUMN_OPTION)) props_u (.*);
`default_nettype wire

// ==== verification/carriage_model.sv ====
// Carriage model giving tab stops and pin digits.
`timescale 1ns/1ns
`default_nettype none
module carriage_model (
	input wire logic clk_sys, // Clock.
	input wire logic reset_n, // Reset, active low.
	input wire logic move, // Start travel.
	output logic atTabStop, // At a stop.
	output logic [3:0] columnPins // Pin digit.
);
	logic [3:0] cnt;
	logic [3:0] col;
	// Each move travels five cycles to the next pinned column.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 4'h0;
			col <= 4'h0;
		end else if (move) begin
			cnt <= 4'h5;
			col <= (col == 4'h9) ? 4'h0 : col + 4'h1;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	assign atTabStop = (cnt == 4'h0);
	// Between stops the pins show a changing pattern.
	assign columnPins = atTabStop ? col : cnt;
endmodule
`default_nettype wire

// ==== verification/index_switch_load_and_column_var_tb.sv ====
// Bench for the index load and column block.
`timescale 1ns/1ns
`default_nettype none
module index_switch_load_and_column_var_tb;
	import index_load_pkg::*;
	logic clk_sys = 0, reset_n = 0, execStrobe = 0, homeFirst = 0, homeSecond = 0, homeBand = 0;
	logic printOrKeyDone = 0, selectColumn = 0, took = 0, atTabStop, columnValid;
	logic [3:0] opCode = 0, accDigit = 0, homeValue = 0, thirdAreaIn = 0, columnPins;
	logic [3:0] firstIndex, secondIndex, columnValue, thirdAreaOut;
	logic [1:0] bandSwitch;
	logic thirdAreaValid, startHold;
	logic [9:0] q[$], qx[$];
	logic [4:0] q3[$];
	logic [3:0] xFirst, xSecond;
	logic [1:0] xBand;
	logic xHold;
	int seed = 32'h0c13c658, n_fail = 0, checks = 0, cyc = 0, fi = 0, si = 0, bi = 0, a;
	index_switch_load_and_column_var dut_u (.*);
	// Expanded machine without the column option, fed the same stimulus.
	index_switch_load_and_column_var #(.EXPANDED_MEMORY(1'b1), .COLUMN_OPTION(1'b0)) exp_u (
		.clk_sys, .reset_n, .execStrobe, .opCode, .accDigit, .homeFirst, .homeSecond,
		.homeBand, .homeValue, .columnPins, .atTabStop, .printOrKeyDone, .selectColumn,
		.thirdAreaIn, .firstIndex(xFirst), .secondIndex(xSecond), .bandSwitch(xBand),
		.columnValue(), .columnValid(), .thirdAreaOut(), .thirdAreaValid(), .startHold(xHold));
	carriage_model car_u (.clk_sys, .reset_n, .move(printOrKeyDone), .atTabStop, .columnPins);
	initial forever #4 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Issue one instruction and note the expected switches.
	task automatic ld(input logic [3:0] op);
		@(negedge clk_sys);
		a = $unsigned($random(seed)) % 10;
		execStrobe = 1;
		opCode = op;
		accDigit = 4'(a);
		thirdAreaIn = 4'(a);
		if (op == OP_LOAD_FIRST || op == OP_LOAD_BOTH) fi = (fi + a) % 10;
		if (op == OP_LOAD_SECOND || op == OP_LOAD_BOTH) si = (si + a) % 10;
		if (op == OP_LOAD_BAND) bi = (bi + a) % 4;
		q.push_back(10'(fi * 16 + si));
		qx.push_back(10'(bi * 256 + fi * 16 + si));
		q3.push_back({1'b1, 4'(a)});
	endtask
	// Compare each load result against the oldest note.
	always @(posedge clk_sys) took <= execStrobe;
	always @(negedge clk_sys) if (took) begin
		chk("index", {bandSwitch, firstIndex, secondIndex}, q.pop_front());
		chk("expanded", {xBand, xFirst, xSecond}, qx.pop_front());
		chk("third pass", {5'h0, thirdAreaValid, thirdAreaOut}, {5'h0, q3.pop_front()});
	end
	// Cut a hang short.
	always @(posedge clk_sys) if (++cyc > 3000) begin
		n_fail++;
		wrap_up;
	end
	// Reset, home, loads back to back, then carriage moves.
	initial begin
		repeat (20) @(negedge clk_sys);
		reset_n = 1;
		@(negedge clk_sys);
		homeFirst = 1;
		homeSecond = 1;
		homeBand = 1;
		@(negedge clk_sys);
		homeFirst = 0;
		homeSecond = 0;
		homeBand = 0;
		for (int i = 0; i < 48; i++) ld(4'(i % 8));
		@(negedge clk_sys);
		execStrobe = 0;
		selectColumn = 1;
		for (int k = 1; k <= 3; k++) begin
			@(negedge clk_sys);
			printOrKeyDone = 1;
			@(negedge clk_sys);
			printOrKeyDone = 0;
			@(negedge clk_sys);
			chk("hold", {7'h0, startHold, thirdAreaValid, columnValid}, 10'h4);
			chk("free run", {9'h0, xHold}, 10'h0);
			while (startHold) @(negedge clk_sys);
			chk("column", {6'h0, columnValue}, 10'(k));
			chk("third", {5'h0, thirdAreaValid, thirdAreaOut}, 10'(16 + k));
		end
		wrap_up;
	end
endmodule
`default_nettype wire
